// ### logic/odc_pkg.sv
// constants and types shared by the output divider configuration block
package odc_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ODC_AW = 12;
  localparam int ODC_DW = 32;
  localparam int ODC_NREG = 10;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] ODC_IDX_DEN_MID = 8'h52;
  localparam logic [7:0] ODC_IDX_DEN_LOW = 8'h53;
  localparam logic [7:0] ODC_IDX_POST_INTHI = 8'h54;
  localparam logic [7:0] ODC_IDX_INT_MID = 8'h55;
  localparam logic [7:0] ODC_IDX_INT_LOW = 8'h56;
  localparam logic [7:0] ODC_IDX_NIBBLES = 8'h57;
  localparam logic [7:0] ODC_IDX_NUM_MID = 8'h58;
  localparam logic [7:0] ODC_IDX_NUM_LOW = 8'h59;
  localparam logic [7:0] ODC_IDX_DIV6 = 8'h5a;
  localparam logic [7:0] ODC_IDX_DIV7 = 8'h5b;
  localparam logic [7:0] ODC_IDX_STATUS = 8'h5c;

  // ****************************************************************
  // positions in the register array (index minus first index)
  // ****************************************************************
  localparam int ODC_P_DEN_MID = 0;
  localparam int ODC_P_DEN_LOW = 1;
  localparam int ODC_P_POST_INTHI = 2;
  localparam int ODC_P_INT_MID = 3;
  localparam int ODC_P_INT_LOW = 4;
  localparam int ODC_P_NIBBLES = 5;
  localparam int ODC_P_NUM_MID = 6;
  localparam int ODC_P_NUM_LOW = 7;
  localparam int ODC_P_DIV6 = 8;
  localparam int ODC_P_DIV7 = 9;

  // ****************************************************************
  // field layout, masks and reset values
  // ****************************************************************
  localparam int ODC_POST_LSB = 4;
  localparam int ODC_POST_MSB = 6;
  localparam int ODC_INTHI_MSB = 1;
  localparam int ODC_NUMHI_MSB = 3;
  localparam int ODC_DENHI_LSB = 4;
  localparam int ODC_DENHI_MSB = 7;
  localparam logic [7:0] ODC_POST_MASK = 8'h73;
  localparam logic [7:0] ODC_FULL_MASK = 8'hff;
  localparam logic [7:0] ODC_CFG_RESET = 8'h00;
  localparam logic [7:0] ODC_RATIO_MIN = 8'h06;
  localparam logic [31:0] ODC_ZERO32 = 32'h0000_0000;

  // status bits
  localparam int ODC_ST_DIV6_BAD = 0;
  localparam int ODC_ST_DIV7_BAD = 1;
  localparam int ODC_ST_ALL_SET = 2;

  // ****************************************************************
  // bus slave states
  // ****************************************************************
  typedef enum logic [1:0] {
    ODC_IDLE = 2'b01,
    ODC_RESP = 2'b10
  } odc_apb_e;

  function automatic logic [ODC_AW-1:0] odc_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : odc_addr

endpackage : odc_pkg

// ### logic/odc_postdiv_if.sv
// link between the configuration slice and the output 5 post-divider
interface odc_postdiv_if;
  logic tick;
  logic [2:0] code;
  logic pulse;
  modport owner (output tick, output code, input pulse);
  modport divider (input tick, input code, output pulse);
endinterface : odc_postdiv_if

// ### logic/odc_postdiv.sv
// power-of-two post-divider for output 5
module odc_postdiv
  import odc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  odc_postdiv_if.divider pd
);

  typedef struct packed {
    logic [6:0] cnt;
    logic pulse;
  } odc_pd_state_s;

  odc_pd_state_s q;
  odc_pd_state_s next_q;
  logic [6:0] limit;

  // R1: ticks per output pulse are two to the power of the code
  assign limit = 7'((8'h01 << pd.code) - 8'h01);

  always_comb begin
    next_q = q;
    next_q.pulse = 1'b0;
    if (pd.tick) begin
      if (q.cnt >= limit) begin
        next_q.cnt = '0;
        next_q.pulse = 1'b1;
      end else begin
        next_q.cnt = 7'(q.cnt + 7'h01);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pd.pulse = q.pulse;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [6:0] gap;
  logic steady;
  logic [2:0] codeQ;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap <= '0;
      steady <= 1'b1;
      codeQ <= '0;
    end else begin
      codeQ <= pd.code;
      if (pd.tick && next_q.pulse) begin
        gap <= '0;
      end else if (pd.tick) begin
        gap <= 7'(gap + 7'h01);
      end
      if (pd.tick && next_q.pulse) begin
        steady <= 1'b1;
      end else if (pd.code != codeQ) begin
        steady <= 1'b0;
      end
    end
  end

  // R1 pulse period
  a_post_period: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    (pd.tick && steady && pd.code == codeQ)
      |-> (next_q.pulse == (gap == limit)))
    else $error("post-divider period differs from two to the code");

  // R1 pulse only from a tick
  a_pulse_from_tick: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    pd.pulse |-> $past(pd.tick))
    else $error("post-divider pulse without an input tick");

endmodule : odc_postdiv

// ### logic/odc_config_regs.sv
// register slice holding divider 5, 6 and 7 settings behind an apb slave
// Behaviour
// R1: output 5 post-divider code in bits 6:4 divides by two to the code.
// R2: integer parameter bits 17:16, 15:8, 7:0 from three successive registers.
// R3: numerator bits 19:16 from low nibble, then two registers for 15:0.
// R4: denominator bits 19:16 come from bits 7:4 of the shared register.
// R5: denominator bits 15:8 and 7:0 come from the first two registers of the block.
// R6: dividers 6 and 7 take a plain 8-bit ratio from one register each.
// R7: software writes only even ratios of six or more to dividers 6 and 7.
// R8: contents are undefined after reset; software writes all before use.
// R9: software writes zero to unused bit 7 and reserved bits 3:2.
//
// Design decision made here: the APB interface to the registers.
module odc_config_regs
  import odc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ODC_AW-1:0] paddr,
  input wire logic [ODC_DW-1:0] pwdata,
  output logic pready,
  output logic [ODC_DW-1:0] prdata,
  output logic pslverr,
  input wire logic vcoTick,
  output logic [17:0] fracdiv5IntegerParam,
  output logic [19:0] fracdiv5NumeratorParam,
  output logic [19:0] fracdiv5DenominatorParam,
  output logic [2:0] output5PostdivSelect,
  output logic [7:0] intdiv6Ratio,
  output logic [7:0] intdiv7Ratio,
  output logic output5Tick
);

  typedef struct packed {
    odc_apb_e st;
    logic [ODC_NREG-1:0][7:0] cfg;
    logic [ODC_NREG-1:0] seen;
    logic ready;
    logic [ODC_DW-1:0] rdata;
    logic slverr;
  } odc_regs_state_s;

  odc_regs_state_s q;
  odc_regs_state_s next_q;
  logic [ODC_NREG-1:0] hit;
  logic [ODC_NREG-1:0][7:0] wmask;
  logic statusHit;
  logic access;
  logic commit;
  logic [7:0] status;
  logic [ODC_DW-1:0] rdMux;

  // ****************************************************************
  // address decode per register
  // ****************************************************************
  for (genvar i = 0; i < ODC_NREG; i++) begin : g_dec
    assign hit[i] = paddr == odc_addr(8'(ODC_IDX_DEN_MID + 8'(i)));
    // R9 reserved bits of the post-divider register are not stored
    assign wmask[i] = (i == ODC_P_POST_INTHI) ? ODC_POST_MASK : ODC_FULL_MASK;
  end

  assign statusHit = paddr == odc_addr(ODC_IDX_STATUS);
  assign access = psel && penable;
  assign commit = (q.st == ODC_RESP) && access && pwrite;

  // R7 ratios that are odd or below six are flagged
  assign status = {5'b0_0000,
    &q.seen,
    q.cfg[ODC_P_DIV7][0] || (q.cfg[ODC_P_DIV7] < ODC_RATIO_MIN),
    q.cfg[ODC_P_DIV6][0] || (q.cfg[ODC_P_DIV6] < ODC_RATIO_MIN)};

  always_comb begin
    rdMux = ODC_ZERO32;
    for (int i = 0; i < ODC_NREG; i++) begin
      if (hit[i]) begin
        rdMux[7:0] = q.cfg[i];
      end
    end
    if (statusHit) begin
      rdMux[7:0] = status;
    end
  end

  // ****************************************************************
  // bus slave and register store
  // ****************************************************************
  always_comb begin
    next_q = q;
    next_q.ready = 1'b0;
    next_q.slverr = 1'b0;
    case (q.st)
      ODC_IDLE: begin
        if (access) begin
          next_q.st = ODC_RESP;
          next_q.ready = 1'b1;
          next_q.rdata = pwrite ? ODC_ZERO32 : rdMux;
          next_q.slverr = !(|hit) && !statusHit;
        end
      end
      ODC_RESP: begin
        next_q.st = ODC_IDLE;
        // R6 each divider ratio is one plain byte register
        for (int i = 0; i < ODC_NREG; i++) begin
          if (commit && hit[i]) begin
            next_q.cfg[i] = pwdata[7:0] & wmask[i];
            next_q.seen[i] = 1'b1;
          end
        end
      end
      default: begin
        next_q.st = ODC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q.st <= ODC_IDLE;
      q.cfg <= {ODC_NREG{ODC_CFG_RESET}};
      q.seen <= '0;
      q.ready <= 1'b0;
      q.rdata <= ODC_ZERO32;
      q.slverr <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign pready = q.ready;
  assign prdata = q.rdata;
  assign pslverr = q.slverr;

  // ****************************************************************
  // divider parameters
  // ****************************************************************
  // R2 integer parameter assembly
  assign fracdiv5IntegerParam = {q.cfg[ODC_P_POST_INTHI][ODC_INTHI_MSB:0],
    q.cfg[ODC_P_INT_MID], q.cfg[ODC_P_INT_LOW]};
  // R3 numerator assembly
  assign fracdiv5NumeratorParam = {q.cfg[ODC_P_NIBBLES][ODC_NUMHI_MSB:0],
    q.cfg[ODC_P_NUM_MID], q.cfg[ODC_P_NUM_LOW]};
  // R4 R5 denominator assembly
  assign fracdiv5DenominatorParam = {
    q.cfg[ODC_P_NIBBLES][ODC_DENHI_MSB:ODC_DENHI_LSB],
    q.cfg[ODC_P_DEN_MID], q.cfg[ODC_P_DEN_LOW]};
  // R1 post-divider code field
  assign output5PostdivSelect =
    q.cfg[ODC_P_POST_INTHI][ODC_POST_MSB:ODC_POST_LSB];
  assign intdiv6Ratio = q.cfg[ODC_P_DIV6];
  assign intdiv7Ratio = q.cfg[ODC_P_DIV7];

  odc_postdiv_if pdIf ();

  assign pdIf.tick = vcoTick;
  assign pdIf.code = output5PostdivSelect;
  assign output5Tick = pdIf.pulse;

  odc_postdiv u_postdiv (
    .core_clk (core_clk),
    .rstn (rstn),
    .pd (pdIf.divider)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_wr(logic [ODC_AW-1:0] a);
    (q.st == ODC_RESP) && psel && penable && pwrite && paddr == a;
  endsequence

  sequence s_req;
    (q.st == ODC_IDLE) && psel && penable;
  endsequence

  // R1 post-divider code taken from write data
  a_post_write: assert property ( // R1
    s_wr(odc_addr(ODC_IDX_POST_INTHI)) |=>
      output5PostdivSelect == $past(pwdata[ODC_POST_MSB:ODC_POST_LSB]))
    else $error("post-divider code not taken from bits 6:4");

  // R2 integer bits 17:16
  a_int_high: assert property ( // R2
    s_wr(odc_addr(ODC_IDX_POST_INTHI)) |=>
      fracdiv5IntegerParam[17:16] == $past(pwdata[ODC_INTHI_MSB:0]))
    else $error("integer parameter high bits wrong");

  // R2 integer bits 7:0, upper bits untouched
  a_int_low: assert property ( // R2
    s_wr(odc_addr(ODC_IDX_INT_LOW)) |=>
      fracdiv5IntegerParam[7:0] == $past(pwdata[7:0]) &&
      $stable(fracdiv5IntegerParam[17:8]))
    else $error("integer parameter low byte wrong");

  // R3 numerator low byte, upper bits untouched
  a_num_bytes: assert property ( // R3
    s_wr(odc_addr(ODC_IDX_NUM_LOW)) |=>
      fracdiv5NumeratorParam[7:0] == $past(pwdata[7:0]) &&
      $stable(fracdiv5NumeratorParam[19:8]))
    else $error("numerator low byte wrong");

  // R3 R4 shared nibble register
  a_nibble_split: assert property ( // R4
    s_wr(odc_addr(ODC_IDX_NIBBLES)) |=>
      fracdiv5DenominatorParam[19:16] == $past(pwdata[7:4]) &&
      fracdiv5NumeratorParam[19:16] == $past(pwdata[3:0]))
    else $error("shared nibble register split wrong");

  // R5 denominator middle byte
  a_den_mid: assert property ( // R5
    s_wr(odc_addr(ODC_IDX_DEN_MID)) |=>
      fracdiv5DenominatorParam[15:8] == $past(pwdata[7:0]) &&
      $stable(fracdiv5DenominatorParam[7:0]))
    else $error("denominator middle byte wrong");

  // R6 plain ratio registers
  a_ratio_six: assert property ( // R6
    s_wr(odc_addr(ODC_IDX_DIV6)) |=>
      intdiv6Ratio == $past(pwdata[7:0]) && $stable(intdiv7Ratio))
    else $error("divider 6 ratio not stored");

  // R6 ratio readback
  a_ratio_read: assert property ( // R6
    s_req ##0 (!pwrite && paddr == odc_addr(ODC_IDX_DIV7))
      |=> pready && prdata[7:0] == intdiv7Ratio)
    else $error("divider 7 ratio readback wrong");

  // APB design decision: answer comes once, one cycle after the access phase opens
  a_ready_once: assert property ( // APB
    s_req |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

endmodule : odc_config_regs

// ### bench/odc_config_regs_tb_top.sv
// self-checking testbench for the output divider configuration slice
module odc_config_regs_tb_top
  import odc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // signals and design instance
  // ****************************************************************
  logic core_clk, rstn, psel, penable, pwrite, vcoTick, tickEn;
  logic [ODC_AW-1:0] paddr;
  logic [ODC_DW-1:0] pwdata, prdata;
  logic pready, pslverr, output5Tick;
  logic [17:0] intParam;
  logic [19:0] numParam, denParam;
  logic [2:0] postSel;
  logic [7:0] ratio6, ratio7;
  int errorCnt = 0;
  int compares = 0;
  logic [7:0] idxTab[10] = '{ODC_IDX_DEN_MID, ODC_IDX_DEN_LOW,
    ODC_IDX_POST_INTHI, ODC_IDX_INT_MID, ODC_IDX_INT_LOW, ODC_IDX_NIBBLES,
    ODC_IDX_NUM_MID, ODC_IDX_NUM_LOW, ODC_IDX_DIV6, ODC_IDX_DIV7};
  logic [7:0] valTab[10] = '{8'ha5, 8'h3c, 8'h73, 8'h12, 8'h34, 8'h9e,
    8'h56, 8'h78, 8'h07, 8'h08};

  odc_config_regs i_dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .vcoTick(vcoTick),
    .fracdiv5IntegerParam(intParam), .fracdiv5NumeratorParam(numParam),
    .fracdiv5DenominatorParam(denParam), .output5PostdivSelect(postSel),
    .intdiv6Ratio(ratio6), .intdiv7Ratio(ratio7),
    .output5Tick(output5Tick)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // vco enable pulses every other cycle while enabled
  always @(posedge core_clk) begin
    vcoTick <= tickEn & ~vcoTick;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    // request holds until pready is sampled high at a rising edge
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errorCnt++;
        final_report();
      end
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                        input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk(rd, exp);
    chk({31'h0000_0000, err}, {31'h0000_0000, expErr});
  endtask : rd_chk

  // counts the falling edges without a divider pulse before the next pulse, one less than the cycles to it
  task automatic wait_tick(output int n);
    n = 0;
    @(negedge core_clk);
    while (output5Tick !== 1'b1) begin
      n++;
      if (n > 1000) begin
        errorCnt++;
        final_report();
      end
      @(negedge core_clk);
    end
  endtask : wait_tick

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int gap;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tickEn = 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk(32'(denParam), 32'h0000_0000);
    rd_chk(ODC_IDX_STATUS, 32'h0000_0003, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wr(idxTab[i], valTab[i]);
    end
    @(negedge core_clk);
    chk(32'(intParam), 32'h0003_1234);
    chk(32'(numParam), 32'h000e_5678);
    chk(32'(denParam), 32'h0009_a53c);
    chk(32'(postSel), 32'h0000_0007);
    chk({ratio7, ratio6}, 32'h0000_0807);
    for (int i = 0; i < 10; i++) begin
      rd_chk(idxTab[i], 32'(valTab[i] & (i == 2 ? 8'h73 : 8'hff)), 1'b0);
    end
    rd_chk(ODC_IDX_STATUS, 32'h0000_0005, 1'b0);
    wr(ODC_IDX_STATUS, 8'hff);
    rd_chk(ODC_IDX_STATUS, 32'h0000_0005, 1'b0);
    wr(ODC_IDX_DIV6, 8'h06);
    wr(ODC_IDX_DIV7, 8'h05);
    rd_chk(ODC_IDX_STATUS, 32'h0000_0006, 1'b0);
    wr(8'h60, 8'haa);
    rd_chk(8'h60, 32'h0000_0000, 1'b1);
    rd_chk(ODC_IDX_DIV6, 32'h0000_0006, 1'b0);
    // post-divider period for every code
    @(posedge core_clk);
    tickEn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(ODC_IDX_POST_INTHI, {1'b0, 3'(c), 4'h0});
      wait_tick(gap);
      wait_tick(gap);
      wait_tick(gap);
      chk(32'(postSel), 32'(c));
      chk(32'(gap + 1), 32'(2 << c));
    end
    @(posedge core_clk);
    tickEn <= 1'b0;
    // second reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({4'h0, ratio6, denParam}, 32'h0000_0000);
    final_report();
  end

endmodule : odc_config_regs_tb_top
